// ==== rtl/ahpk_map.svh ====
// Purpose: Register offsets, fields, reset values and timing for the host power block
// Assumes: 20 MHz clock, APB byte addresses
// Notes:   Times kept in their own units; cycle counts derived here
`ifndef AHPK_MAP_SVH
`define AHPK_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AHPK_OFS_FUNC 8'h00
`define AHPK_OFS_PULSE 8'h04
`define AHPK_OFS_SRC 8'h08
`define AHPK_OFS_CMD 8'h0c
`define AHPK_OFS_STAT 8'h10

// ------------------------------------------------------------
// Function byte fields
// ------------------------------------------------------------
`define AHPK_F_AUTO 0
`define AHPK_F_PWR_INV 2
`define AHPK_F_RST_INV 3
`define AHPK_F_BLANK 4
`define AHPK_F_RST_EN 5
`define AHPK_F_ON_EN 6
`define AHPK_F_OFF_EN 7

// ------------------------------------------------------------
// Reset values and commands
// ------------------------------------------------------------
`define AHPK_FUNC_RST 8'h00
`define AHPK_PULSE_RST 8'h20
`define AHPK_SRC_RST 2'h0
`define AHPK_CMD_SAVE 8'h04

// ------------------------------------------------------------
// Timing: one tick is 1/32 s, so pulse value 16 is half a second
// ------------------------------------------------------------
`define AHPK_CLK_MHZ 20
`define AHPK_TICK_US 31250
`define AHPK_TICK_CYC (`AHPK_TICK_US * `AHPK_CLK_MHZ)
`define AHPK_ON_HOLD_MS 250
`define AHPK_LONG_HOLD_MS 4000
`define AHPK_RST_MS 1000
`define AHPK_EXT_MS 5000
`define AHPK_MS_TICKS(ms) ((ms) * 1000 / `AHPK_TICK_US)

`endif

// ==== rtl/ahpk_pkg.sv ====
// Purpose: Types for the host power block
// Assumes: Constants live in ahpk_map.svh
// Notes:   Gray codes along the declared order, idle through boot
package ahpk_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_HOLD = 3'h1,
        ST_PWR = 3'h3,
        ST_EXT = 3'h2,
        ST_RST = 3'h6,
        ST_BOOT = 3'h7
    } ahpk_state_type;

    typedef enum logic [1:0]
    {
        ACT_ON = 2'h0,
        ACT_OFF = 2'h1,
        ACT_RST = 2'h2,
        ACT_WD = 2'h3
    } ahpk_act_type;

endpackage : ahpk_pkg

// ==== rtl/ahpk_top.sv ====
// Purpose: Keypad and watchdog control of host power and reset switches
// Assumes: Keys, sense pins and pin readbacks are asynchronous; APB on clk
// Notes:   Pins are split into in, out and enable; the bench resolves wires
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "ahpk_map.svh"

module ahpk_top
    import ahpk_pkg::*;
#(
    parameter int TICK_CYC = `AHPK_TICK_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enterKey,
    input wire logic cancelKey,
    input wire logic senseUsb,
    input wire logic senseAux,
    input wire logic senseGpio1,
    input wire logic wdReq,
    input wire logic pwrIn,
    output logic pwrOut,
    output logic pwrOe,
    input wire logic rstIn,
    output logic rstOut,
    output logic rstOe,
    output logic blankDisplay,
    output logic selfRestart
);

    localparam logic [7:0] ON_TICKS = 8'(`AHPK_MS_TICKS(`AHPK_ON_HOLD_MS));
    localparam logic [7:0] LONG_TICKS = 8'(`AHPK_MS_TICKS(`AHPK_LONG_HOLD_MS));
    localparam logic [7:0] RST_TICKS = 8'(`AHPK_MS_TICKS(`AHPK_RST_MS));
    localparam logic [7:0] EXT_TICKS = 8'(`AHPK_MS_TICKS(`AHPK_EXT_MS));

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [7:0] meta_q;
    logic [7:0] sync_q;

    // Two stages on every key, sense, watchdog and pin readback input before any logic sees it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end
        else
        begin
            meta_q <= {rstIn, pwrIn, wdReq, senseGpio1, senseAux, senseUsb, cancelKey, enterKey};
            sync_q <= meta_q;
        end
    end

    logic enterS, cancelS, wdS, pwrInS, rstInS;
    assign enterS = sync_q[0];
    assign cancelS = sync_q[1];
    assign wdS = sync_q[5];
    assign pwrInS = sync_q[6];
    assign rstInS = sync_q[7];

    // ------------------------------------------------------------
    // Configuration, live and saved boot copy
    // ------------------------------------------------------------
    logic [7:0] func_q, pulse_q, bootFunc_q, bootPulse_q;
    logic [1:0] src_q, bootSrc_q;
    ahpk_state_type state_q;
    logic apbWr, apbSetup, reboot;
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pwrite;
    assign reboot = (state_q == ST_BOOT);

    function automatic logic is_mapped(input logic [31:0] a);
        is_mapped = (a == 32'(`AHPK_OFS_FUNC)) || (a == 32'(`AHPK_OFS_PULSE)) || (a == 32'(`AHPK_OFS_SRC))
                 || (a == 32'(`AHPK_OFS_CMD)) || (a == 32'(`AHPK_OFS_STAT));
    endfunction : is_mapped

    // Restart reloads the saved state; reset loads the reset values instead
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            func_q <= `AHPK_FUNC_RST;
            pulse_q <= `AHPK_PULSE_RST;
            src_q <= `AHPK_SRC_RST;
        end
        else if (reboot)
        begin
            func_q <= bootFunc_q;
            pulse_q <= bootPulse_q;
            src_q <= bootSrc_q;
        end
        else if (apbWr)
        begin
            if (paddr == 32'(`AHPK_OFS_FUNC))
                func_q <= pwdata[7:0];
            if (paddr == 32'(`AHPK_OFS_PULSE))
                pulse_q <= pwdata[7:0];
            if (paddr == 32'(`AHPK_OFS_SRC))
                src_q <= pwdata[1:0];
        end
    end

    // Save command snapshots live configuration
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bootFunc_q <= `AHPK_FUNC_RST;
            bootPulse_q <= `AHPK_PULSE_RST;
            bootSrc_q <= `AHPK_SRC_RST;
        end
        else if (apbWr && paddr == 32'(`AHPK_OFS_CMD) && pwdata[7:0] == `AHPK_CMD_SAVE)
        begin
            bootFunc_q <= func_q;
            bootPulse_q <= pulse_q;
            bootSrc_q <= src_q;
        end
    end

    // ------------------------------------------------------------
    // Sense selection and blanking
    // ------------------------------------------------------------
    logic senseNow;
    always_comb
    begin
        unique case (src_q)
            2'h1: senseNow = sync_q[2];
            2'h2: senseNow = sync_q[4];
            default: senseNow = sync_q[3];
        endcase
    end

    assign blankDisplay = func_q[`AHPK_F_BLANK] && !senseNow;

    // ------------------------------------------------------------
    // Tick divider, restarted on every state change
    // ------------------------------------------------------------
    logic [19:0] div_q;
    logic tickEn, stChg;
    assign tickEn = (div_q == 20'(TICK_CYC - 1));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_q <= 20'h00000;
        else if (stChg || tickEn)
            div_q <= 20'h00000;
        else
            div_q <= div_q + 20'h00001;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    ahpk_state_type state_d;
    ahpk_act_type act_q, act_d;
    logic [7:0] cnt_q;
    logic armed_q, wdPrev_q, drvLvl_q, keyHeld, wdRise;
    logic [7:0] holdNeed;

    assign keyHeld = (act_q == ACT_OFF) ? cancelS : enterS;
    assign wdRise = wdS && !wdPrev_q;
    assign stChg = (state_d != state_q);
    assign holdNeed = (act_q == ACT_ON) ? ON_TICKS : LONG_TICKS;

    // Next state and pending action
    always_comb
    begin
        state_d = state_q;
        act_d = act_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (wdRise)
                begin
                    state_d = ST_RST;
                    act_d = ACT_WD;
                end
                else if (armed_q && cancelS && senseNow && func_q[`AHPK_F_OFF_EN])
                begin
                    state_d = ST_HOLD;
                    act_d = ACT_OFF;
                end
                else if (armed_q && enterS && !senseNow && func_q[`AHPK_F_ON_EN])
                begin
                    state_d = ST_HOLD;
                    act_d = ACT_ON;
                end
                else if (armed_q && enterS && senseNow && func_q[`AHPK_F_RST_EN])
                begin
                    state_d = ST_HOLD;
                    act_d = ACT_RST;
                end
            end
            ST_HOLD:
            begin
                if (!keyHeld)
                    state_d = ST_IDLE;
                else if (cnt_q >= holdNeed)
                    state_d = (act_q == ACT_RST) ? ST_RST : ST_PWR;
            end
            ST_PWR:
            begin
                if (cnt_q >= pulse_q)
                    state_d = (act_q == ACT_OFF && cancelS) ? ST_EXT : ST_IDLE;
            end
            ST_EXT:
            begin
                if (!cancelS || cnt_q >= EXT_TICKS)
                    state_d = ST_IDLE;
            end
            ST_RST:
            begin
                if (cnt_q >= RST_TICKS)
                    state_d = (act_q == ACT_RST) ? ST_BOOT : ST_IDLE;
            end
            ST_BOOT:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // State, action and tick count; count measured from entry into each state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            act_q <= ACT_ON;
            cnt_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            act_q <= act_d;
            if (stChg)
                cnt_q <= 8'h00;
            else if (tickEn && cnt_q != 8'hff)
                cnt_q <= cnt_q + 8'h01;
        end
    end

    // A key still held across a reboot must be released before it counts again
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            armed_q <= 1'b0;
            wdPrev_q <= 1'b0;
        end
        else
        begin
            wdPrev_q <= wdS;
            if (!enterS && !cancelS)
                armed_q <= 1'b1;
            else if (state_q != ST_IDLE)
                armed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive; auto polarity drives against the idle pull level
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            drvLvl_q <= 1'b0;
        else if (state_q == ST_HOLD || state_q == ST_IDLE)
        begin
            if (func_q[`AHPK_F_AUTO])
                drvLvl_q <= (state_d == ST_RST) ? !rstInS : !pwrInS;
            else if (state_d == ST_RST)
                drvLvl_q <= func_q[`AHPK_F_RST_INV];
            else
                drvLvl_q <= func_q[`AHPK_F_PWR_INV];
        end
    end

    assign pwrOe = (state_q == ST_PWR) || (state_q == ST_EXT);
    assign pwrOut = pwrOe && drvLvl_q;
    assign rstOe = (state_q == ST_RST);
    assign rstOut = rstOe && drvLvl_q;
    assign selfRestart = reboot;

    // ------------------------------------------------------------
    // APB slave, zero wait states, read data captured in setup
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (apbSetup && !pwrite)
        begin
            unique case (paddr)
                32'(`AHPK_OFS_FUNC): prdata <= {24'h000000, func_q};
                32'(`AHPK_OFS_PULSE): prdata <= {24'h000000, pulse_q};
                32'(`AHPK_OFS_SRC): prdata <= {30'h00000000, src_q};
                32'(`AHPK_OFS_STAT): prdata <= {24'h000000, state_q, act_q, blankDisplay, rstOe, senseNow};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_rst_hiz;
        @(posedge clk) disable iff (rst) (state_q != ST_RST) |-> !rstOe;
    endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("reset pin driven outside reset");

    property p_rst_lvl;
        @(posedge clk) disable iff (rst)
            $rose(rstOe) && !func_q[`AHPK_F_AUTO] |-> rstOut == func_q[`AHPK_F_RST_INV];
    endproperty
    a_rst_lvl: assert property (p_rst_lvl) else $error("reset level ignores polarity");

    property p_pwr_lvl;
        @(posedge clk) disable iff (rst)
            $rose(pwrOe) && !func_q[`AHPK_F_AUTO] |-> pwrOut == func_q[`AHPK_F_PWR_INV];
    endproperty
    a_pwr_lvl: assert property (p_pwr_lvl) else $error("power level ignores polarity");

    property p_wd;
        @(posedge clk) disable iff (rst) (state_q == ST_IDLE) && wdRise |=> rstOe;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog did not reset host");

    property p_on_en;
        @(posedge clk) disable iff (rst) $rose(pwrOe) && act_q == ACT_ON |-> func_q[`AHPK_F_ON_EN];
    endproperty
    a_on_en: assert property (p_on_en) else $error("disabled power-on drove pin");

    property p_blank;
        @(posedge clk) disable iff (rst) !senseNow && func_q[`AHPK_F_BLANK] |-> blankDisplay;
    endproperty
    a_blank: assert property (p_blank) else $error("display not blanked");

    property p_reboot;
        @(posedge clk) disable iff (rst) $fell(rstOe) && act_q == ACT_RST |-> selfRestart ##1 !selfRestart;
    endproperty
    a_reboot: assert property (p_reboot) else $error("no restart after keypad reset");

    property p_cancel;
        @(posedge clk) disable iff (rst) state_q == ST_HOLD && !keyHeld |=> state_q == ST_IDLE && !pwrOe && !rstOe;
    endproperty
    a_cancel: assert property (p_cancel) else $error("early release not cancelled");

    property p_ext_cap;
        @(posedge clk) disable iff (rst) state_q == ST_EXT |-> cnt_q <= EXT_TICKS;
    endproperty
    a_ext_cap: assert property (p_ext_cap) else $error("extension beyond cap");

    property p_pwr_min;
        @(posedge clk) disable iff (rst) $fell(pwrOe) |-> $past(cnt_q) >= pulse_q || $past(state_q) == ST_EXT;
    endproperty
    a_pwr_min: assert property (p_pwr_min) else $error("power pulse too short");

    c_on: cover property (@(posedge clk) disable iff (rst) $rose(pwrOe) && act_q == ACT_ON);
    c_ext: cover property (@(posedge clk) disable iff (rst) state_q == ST_EXT);
    c_boot: cover property (@(posedge clk) disable iff (rst) selfRestart);

endmodule : ahpk_top

// ==== test/ahpk_switch_input.sv ====
// Purpose: Motherboard front-panel switch input, pulled up, with pulse timer
// Assumes: Only the block ever drives the pin
// Notes:   Length and level of each driven pulse kept for the bench
`timescale 1ns/100ps

module ahpk_switch_input
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel,
    output logic [7:0] pulseCount,
    output logic [31:0] lastLen,
    output logic lastLevel
);
    logic [31:0] run_q;
    logic [31:0] len_q;
    logic [7:0] cnt_q;
    logic lvl_q;

    // Pin kept as a switch input only; pull-up wins when released
    assign pinLevel = pinOe ? pinOut : 1'b1;
    assign pulseCount = cnt_q;
    assign lastLen = len_q;
    assign lastLevel = lvl_q;

    // Time each drive, booked when the block lets go
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_q <= 32'h0;
            len_q <= 32'h0;
            cnt_q <= 8'h0;
            lvl_q <= 1'b0;
        end
        else if (pinOe)
        begin
            run_q <= run_q + 32'h1;
            lvl_q <= pinOut;
        end
        else if (run_q != 32'h0)
        begin
            len_q <= run_q;
            cnt_q <= cnt_q + 8'h1;
            run_q <= 32'h0;
        end
    end
endmodule : ahpk_switch_input

// ==== test/test_ahpk_top.sv ====
// Purpose: Self-checking bench for the host power and reset switch block
// Assumes: Tick shortened to T clocks so holds of seconds stay short
// Notes:   Pin levels come from the two switch input models
`timescale 1ns/100ps
`include "ahpk_map.svh"
`define AHPK_CHK(got, exp, msg) \
    begin \
        checksDone++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("mismatch at %0t: %s", $time, msg); \
        end \
    end

module test_ahpk_top;
    localparam int T = 20;
    logic clk = 1'b0, rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic enterKey = 1'b0, cancelKey = 1'b0, wdReq = 1'b0;
    logic senseUsb = 1'b0, senseAux = 1'b0, senseGpio1 = 1'b0;
    wire logic [31:0] prdata, pwrLen, rstLen;
    wire logic [7:0] pwrCount, rstCount;
    wire logic pready, pslverr, pwrIn, pwrOut, pwrOe, rstIn, rstOut, rstOe;
    wire logic blankDisplay, selfRestart, pwrLvl, rstLvl;
    int fails = 0, checksDone = 0, restarts = 0;

    // ------------------------------------------------------------
    // Clock, design and switch models
    // ------------------------------------------------------------
    always #25 clk = ~clk;

    ahpk_top #(.TICK_CYC(T)) u_ahpk_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enterKey(enterKey), .cancelKey(cancelKey), .senseUsb(senseUsb),
        .senseAux(senseAux), .senseGpio1(senseGpio1), .wdReq(wdReq), .pwrIn(pwrIn),
        .pwrOut(pwrOut), .pwrOe(pwrOe), .rstIn(rstIn), .rstOut(rstOut), .rstOe(rstOe),
        .blankDisplay(blankDisplay), .selfRestart(selfRestart));
    ahpk_switch_input u_ahpk_switch_input_pwr (.clk(clk), .rst(rst), .pinOut(pwrOut), .pinOe(pwrOe),
        .pinLevel(pwrIn), .pulseCount(pwrCount), .lastLen(pwrLen), .lastLevel(pwrLvl));
    ahpk_switch_input u_ahpk_switch_input_rst (.clk(clk), .rst(rst), .pinOut(rstOut), .pinOe(rstOe),
        .pinLevel(rstIn), .pulseCount(rstCount), .lastLen(rstLen), .lastLevel(rstLvl));

    // Restart pulses are one cycle, so count them as they pass
    always @(posedge clk)
    begin
        if (selfRestart === 1'b1)
            restarts <= restarts + 1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states are the slave's choice; only the hang guard ends a stuck wait
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic apb_write(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, addr, wd, rd, err);
    endtask : apb_write

    task automatic apb_check(input logic [31:0] addr, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        `AHPK_CHK(rd, exp, "register read")
        `AHPK_CHK(err, expErr, "slave error")
    endtask : apb_check

    // Holds one key for a number of clocks, then lets both go
    task automatic press(input logic isCancel, input int cycles);
        @(posedge clk);
        if (isCancel)
            cancelKey <= 1'b1;
        else
            enterKey <= 1'b1;
        repeat (cycles) @(posedge clk);
        enterKey <= 1'b0;
        cancelKey <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : press

    // Bounded wait for a pin model to book a new pulse
    task automatic wait_pulse(input logic onRst, input logic [7:0] prev, input int limit);
        int n;
        n = 0;
        while (((onRst ? rstCount : pwrCount) === prev) && n < limit)
        begin
            @(posedge clk);
            n++;
        end
        `AHPK_CHK(n < limit, 1'b1, "pulse missing")
    endtask : wait_pulse

    task automatic chk_len(input logic [31:0] got, input int lo, input int hi);
        `AHPK_CHK((got >= lo) && (got <= hi), 1'b1, "pulse length")
    endtask : chk_len

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_after_reset;
        apb_check(`AHPK_OFS_FUNC, 32'h0, 1'b0);
        apb_check(`AHPK_OFS_PULSE, 32'h20, 1'b0);
        apb_check(`AHPK_OFS_SRC, 32'h0, 1'b0);
        apb_check(32'h14, 32'h0, 1'b1);
        apb_check(`AHPK_OFS_CMD, 32'h0, 1'b0);
        apb_check(`AHPK_OFS_STAT, 32'h0, 1'b0);
        `AHPK_CHK({pwrOe, rstOe}, 2'b00, "pins idle")
        $display("test after_reset done");
    endtask : t_after_reset

    task automatic t_power_on;
        logic [7:0] p0;
        senseAux <= 1'b0;
        senseUsb <= 1'b1;
        senseGpio1 <= 1'b1;
        p0 = pwrCount;
        press(1'b0, 12 * T);
        `AHPK_CHK(pwrCount, p0, "disabled power-on drove")
        apb_write(`AHPK_OFS_PULSE, 32'h10);
        apb_write(`AHPK_OFS_FUNC, 32'h44);
        press(1'b0, 4 * T);
        repeat (20 * T) @(posedge clk);
        `AHPK_CHK(pwrCount, p0, "early release drove")
        press(1'b0, 12 * T);
        wait_pulse(1'b0, p0, 30 * T);
        chk_len(pwrLen, 16 * T, 16 * T + 1);
        `AHPK_CHK(pwrLvl, 1'b1, "power level")
        $display("test power_on done");
    endtask : t_power_on

    task automatic t_hard_off;
        logic [7:0] p0;
        senseAux <= 1'b1;
        senseUsb <= 1'b0;
        senseGpio1 <= 1'b0;
        apb_write(`AHPK_OFS_FUNC, 32'hf1);
        p0 = pwrCount;
        press(1'b1, 100 * T);
        `AHPK_CHK(pwrCount, p0, "short cancel drove")
        press(1'b1, 168 * T);
        wait_pulse(1'b0, p0, 20 * T);
        chk_len(pwrLen, 40 * T - 3, 40 * T + 4);
        `AHPK_CHK(pwrLvl, 1'b0, "auto polarity level")
        p0 = pwrCount;
        press(1'b1, 334 * T);
        wait_pulse(1'b0, p0, 10 * T);
        chk_len(pwrLen, 176 * T - 1, 176 * T + 2);
        $display("test hard_off done");
    endtask : t_hard_off

    task automatic t_hard_reset;
        logic [7:0] r0, p0;
        int s0;
        apb_write(`AHPK_OFS_CMD, {24'h0, `AHPK_CMD_SAVE});
        apb_write(`AHPK_OFS_PULSE, 32'h30);
        r0 = rstCount;
        p0 = pwrCount;
        s0 = restarts;
        press(1'b0, 130 * T);
        wait_pulse(1'b1, r0, 40 * T);
        chk_len(rstLen, 32 * T, 32 * T + 1);
        `AHPK_CHK(rstLvl, 1'b0, "reset level")
        `AHPK_CHK(pwrCount, p0, "power pin moved")
        repeat (8) @(posedge clk);
        `AHPK_CHK(restarts, s0 + 1, "restart count")
        apb_check(`AHPK_OFS_PULSE, 32'h10, 1'b0);
        $display("test hard_reset done");
    endtask : t_hard_reset

    task automatic t_watchdog;
        logic [7:0] r0;
        int s0;
        apb_write(`AHPK_OFS_FUNC, 32'h08);
        r0 = rstCount;
        s0 = restarts;
        @(posedge clk);
        wdReq <= 1'b1;
        repeat (4) @(posedge clk);
        wdReq <= 1'b0;
        wait_pulse(1'b1, r0, 40 * T);
        chk_len(rstLen, 32 * T, 32 * T + 1);
        `AHPK_CHK(rstLvl, 1'b1, "inverted reset level")
        `AHPK_CHK(restarts, s0, "watchdog restarted")
        r0 = rstCount;
        press(1'b0, 140 * T);
        `AHPK_CHK(rstCount, r0, "disabled reset drove")
        $display("test watchdog done");
    endtask : t_watchdog

    task automatic t_blank;
        apb_write(`AHPK_OFS_FUNC, 32'h10);
        for (int s = 0; s < 4; s++)
        begin
            apb_write(`AHPK_OFS_SRC, 32'(s));
            for (int v = 0; v < 2; v++)
            begin
                @(posedge clk);
                senseAux <= (s == 0 || s == 3) ? v[0] : ~v[0];
                senseUsb <= (s == 1) ? v[0] : ~v[0];
                senseGpio1 <= (s == 2) ? v[0] : ~v[0];
                repeat (5) @(posedge clk);
                `AHPK_CHK(blankDisplay, ~v[0], "blank level")
            end
        end
        apb_write(`AHPK_OFS_FUNC, 32'h0);
        repeat (3) @(posedge clk);
        `AHPK_CHK(blankDisplay, 1'b0, "blank while disabled")
        $display("test blank done");
    endtask : t_blank

    // ------------------------------------------------------------
    // Verdict, sequence and hang guard
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Main sequence after five reset cycles
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_after_reset();
        t_power_on();
        t_hard_off();
        t_hard_reset();
        t_watchdog();
        t_blank();
        tally_and_finish();
    end

    // Run needs about 20k clocks; allow twice that
    initial
    begin
        #2000000;
        fails++;
        $display("mismatch at %0t: timeout", $time);
        tally_and_finish();
    end
endmodule : test_ahpk_top
